// ==== dv/afe_eq_front_end_sva.sv ====
`timescale 1ns/1ps
module afe_eq_front_end_sva
    import afe_pkg::*;
(
    // Clock and resets.
    input wire logic        core_clk_i,
    input wire logic        sys_rst_i,
    input wire logic        ext_rst_n_i,
    // Bus.
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // Stream.
    input wire logic        eq_out_valid_o,
    input wire afe_pair_t   eq_out_o
);
    logic        seen_r;
    logic [11:0] gap_r;
    wire         acc = psel_i && penable_i;
    wire         clr = eq_out_o == '0 && !eq_out_valid_o && prdata_o == '0;

    // Counts cycles between output pulses; seen_r waits for the first pulse.
    always_ff @(posedge core_clk_i)
    begin
        seen_r <= !(sys_rst_i || !ext_rst_n_i) && (seen_r || eq_out_valid_o);
        gap_r  <= eq_out_valid_o ? 12'h001 : gap_r + {11'h000, ~&gap_r};
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i || !ext_rst_n_i);
    // Bus handshake, decode and read data.
    bus_ready_a: assert property (pready_o == acc)
        else $error("bad pready");
    err_decode_a: assert property (acc && paddr_i[1:0] == 2'b00 |-> pslverr_o == (paddr_i > REG_PERIOD))
        else $error("bad pslverr");
    err_zero_a: assert property (acc && !pwrite_i && pslverr_o |-> prdata_o == '0)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (acc |=> $stable(prdata_o))
        else $error("read data moved");
    // Outputs are cleared by either reset.
    rst_clear_a: assert property ($fell(sys_rst_i) |-> clr)
        else $error("outputs not cleared");
    pin_clear_a: assert property (disable iff (sys_rst_i) !ext_rst_n_i |-> clr)
        else $error("pin reset not clearing");
    // Output pulses are single and paced by the processing rate.
    pulse_one_a: assert property (eq_out_valid_o |=> !eq_out_valid_o [*8])
        else $error("valid too long");
    rate_gap_a: assert property (eq_out_valid_o && seen_r |-> gap_r >= 12'h7C6 && gap_r <= 12'h884)
        else $error("valid spacing off");
endmodule

bind afe_eq_front_end afe_eq_front_end_sva u_sva (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .ext_rst_n_i(ext_rst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .eq_out_valid_o(eq_out_valid_o), .eq_out_o(eq_out_o)
);

// ==== dv/afe_src_model.sv ====
`timescale 1ns/1ps
module afe_src_model
    import afe_pkg::*;
(
    // Frame content and layout.
    input  wire logic       run_i,
    input  wire afe_pair_t  pair_i,
    input  wire logic [2:0] fmt_i,
    // Serial audio lines.
    output logic            audio_bit_clock_o,
    output logic            frame_word_clock_o,
    output logic            serial_audio_in_o
);
    int          idx;
    afe_pair_t   p;
    logic [2:0]  f;
    logic [23:0] w;

    // One 64-bit frame every 10240 ns; the bit clock stands high between frames.
    initial
    begin
        audio_bit_clock_o  = 1'b1;
        frame_word_clock_o = 1'b1;
        serial_audio_in_o  = 1'b0;
        forever
        begin
            #8320;
            if (run_i)
            begin
                p = pair_i;
                f = fmt_i;
                for (int k = 0; k < 64; k++)
                begin
                    audio_bit_clock_o  = 1'b0;
                    frame_word_clock_o = k[5] ^ (f[1:0] == 2'b01 || f[1:0] == 2'b10);
                    w   = k[5] ? p.right : p.left;
                    idx = (k % 32) - (f[1:0] == 2'b01 ? 0 : (f[1:0] == 2'b10 ? 8 : 1));
                    // Slots outside the word carry a toggling pattern.
                    if (idx >= 0 && idx < 24)
                        serial_audio_in_o = w[f[2] ? idx : 23 - idx];
                    else
                        serial_audio_in_o = ~serial_audio_in_o;
                    #15 audio_bit_clock_o = 1'b1;
                    #15;
                end
                serial_audio_in_o = ~serial_audio_in_o;
            end
        end
    end
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
    import afe_pkg::*;
;
    logic        clk = 1'b0;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  pa = 8'h00;
    logic [31:0] pwd = 32'h0000_0000;
    logic        run = 1'b0;
    logic [2:0]  sfmt = 3'h0;
    afe_pair_t   spair = '0;
    logic [31:0] prd;
    logic        prdy;
    logic        perr;
    logic        bclk;
    logic        wclk;
    logic        sdin;
    logic        vld;
    afe_pair_t   dout;
    logic [31:0] rd;
    logic        er;
    int          mismatches = 0;
    int          samples_checked = 0;
    logic [31:0] dflt [5] = '{32'h0000_0000, 32'h0000_0030, 32'h0000_0000, 32'h0000_0060, 32'h0000_0100};
    // Each step packs control [23:20], format [19:12] and gain code [11:0].
    logic [23:0] step_tbl [11] = '{24'h03_0060, 24'h23_0060, 24'h43_0060, 24'h10_0060, 24'h11_0060,
        24'h12_0060, 24'h13_1060, 24'h13_2060, 24'h13_4060, 24'h13_0054, 24'h63_006C};

    // Core clock and a master clock of 256 per frame.
    initial forever #2.5 clk = ~clk;
    initial forever #20 mclk = ~mclk;

    afe_eq_front_end dut (
        .core_clk_i(clk), .sys_rst_i(rst), .ext_rst_n_i(rst_n), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
        .audio_bit_clock_i(bclk), .frame_word_clock_i(wclk), .serial_audio_in_i(sdin),
        .master_clock_in_i(mclk), .eq_out_valid_o(vld), .eq_out_o(dout)
    );
    afe_src_model src (
        .run_i(run), .pair_i(spair), .fmt_i(sfmt), .audio_bit_clock_o(bclk),
        .frame_word_clock_o(wclk), .serial_audio_in_o(sdin)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus transfer; the answer is taken at the edge where pready is high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr  <= wr;
        pa   <= a;
        pwd  <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
            @(posedge clk);
        while (prdy !== 1'b1);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask

    task automatic wait_vld(input int k);
        repeat (k)
        begin
            @(posedge clk);
            while (vld !== 1'b1)
                @(posedge clk);
        end
    endtask

    // Bypassed channels keep the masked word and gain; others see zeroed sections.
    function automatic logic [23:0] expect_ch(input logic [23:0] d, input logic [23:0] c, input logic pass);
        logic [23:0] v;
        v = d & ~((24'h00_0001 << (c[17:16] == 2'h3 ? 0 : 8 - 2 * c[17:16])) - 24'h00_0001);
        if (!pass)
            return 24'h00_0000;
        if (c[11:0] == 12'h054)
            return v << 1;
        if (c[11:0] == 12'h06C)
            return $signed(v) >>> 1;
        return v;
    endfunction

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence: defaults, decode, coefficients, stream steps, pin reset.
    initial
    begin
        logic [23:0] c;
        logic [23:0] lw;
        logic [23:0] rw;
        void'($urandom(32'h0d90_5290));
        repeat (5) @(posedge clk);
        rst   <= 1'b0;
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, 8'(4 * i), 32'h0000_0000);
            check(rd, dflt[i]);
        end
        apb(1'b1, REG_RATIO, 32'h0000_0240);
        apb(1'b0, REG_RATIO, 32'h0000_0000);
        check(rd, 32'h0000_0240);
        apb(1'b1, REG_RATIO, 32'h0000_0100);
        apb(1'b1, 8'h24, 32'hFFFF_FFFF);
        check({31'h0, er}, 32'h0000_0001);
        apb(1'b1, REG_CADDR, 32'h0000_0062);
        repeat (3) apb(1'b1, REG_CDATA, 32'h0000_0000);
        apb(1'b0, REG_CADDR, 32'h0000_0000);
        check(rd, 32'h0000_0065);
        apb(1'b1, REG_CADDR, 32'h0000_0000);
        repeat (100) apb(1'b1, REG_CDATA, 32'h0000_0000);
        apb(1'b1, REG_FILT, 32'h0000_03FF);
        run <= 1'b1;
        foreach (step_tbl[i])
        begin
            c = step_tbl[i];
            lw = 24'($urandom);
            rw = 24'($urandom);
            lw[23] = lw[22];
            rw[23] = rw[22];
            apb(1'b1, REG_CTRL, {28'h0, c[23:20]});
            apb(1'b1, REG_FMT, {24'h0, c[19:12]});
            apb(1'b1, REG_GAIN, {20'h0, c[11:0]});
            sfmt  <= c[14:12];
            spair <= '{lw, rw};
            wait_vld(4);
            check({8'h00, dout.left}, {8'h00, expect_ch(lw, c, c[20] | c[21])});
            check({8'h00, dout.right}, {8'h00, expect_ch(rw, c, c[20] | c[22])});
        end
        apb(1'b0, REG_STAT, 32'h0000_0000);
        check(rd, 32'h0000_0003);
        apb(1'b0, REG_CTRL, 32'h0000_0000);
        @(posedge clk);
        rst_n <= 1'b0;
        #1;
        check(prd, 32'h0000_0000);
        check({8'h00, dout.left}, 32'h0000_0000);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, REG_CTRL, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        give_verdict();
    end

    // Cuts a hang short about 60 us past the expected run length of about 460 us.
    initial
    begin
        #520_000;
        mismatches++;
        give_verdict();
    end
endmodule

// ==== rtl/afe_eq_front_end.sv ====
`timescale 1ns/1ps
module afe_eq_front_end
    import afe_pkg::*;
(
    // Core clock and resets.
    input  wire logic       core_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       ext_rst_n_i,
    // APB slave.
    input  wire logic       psel_i,
    input  wire logic       penable_i,
    input  wire logic       pwrite_i,
    input  wire logic [7:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic            pready_o,
    output logic            pslverr_o,
    // Serial audio link.
    input  wire logic       audio_bit_clock_i,
    input  wire logic       frame_word_clock_i,
    input  wire logic       serial_audio_in_i,
    input  wire logic       master_clock_in_i,
    // Processed stream at the internal rate.
    output logic            eq_out_valid_o,
    output afe_pair_t       eq_out_o
);

    typedef enum logic [1:0] {S_IDLE, S_MAC, S_GAIN} afe_state_t;

    // Logic clocked by the bit clock; cfg_r belongs to the core domain.
    afe_cfg_t    cfg_r;
    logic [4:0]  fmt_s1_r;
    logic [4:0]  fmt_s2_r;
    logic        wc_prev_r;
    logic [23:0] hist_r;
    logic [5:0]  idx_r;
    logic [23:0] left_tmp_r;
    afe_pair_t   link_pair_r;
    logic        frame_tgl_r;

    wire        wc_edge  = frame_word_clock_i != wc_prev_r;
    wire        lsb_mode = fmt_s2_r[2];
    wire [1:0]  frm_mode = fmt_s2_r[1:0];
    wire        rj_mode  = frm_mode == FRM_RIGHT;
    wire        i2s_mode = (frm_mode == FRM_I2S) || (frm_mode == FRM_SPARE);
    logic [4:0] wlen;
    logic [5:0] cur_idx;
    logic [5:0] cap_pos;
    logic [23:0] hist_nxt;
    logic [23:0] cap_src;
    logic [23:0] cap_word;
    logic        cap_lr;
    logic        cap_right;

    // Word length and capture point of the framing in use.
    always_comb
    begin
        case (fmt_s2_r[4:3])
            2'h0:    wlen = 5'h10;
            2'h1:    wlen = 5'h12;
            2'h2:    wlen = 5'h14;
            default: wlen = 5'h18;
        endcase
    end

    // Shift in the new bit, find the word end and left-align the word.
    assign hist_nxt  = lsb_mode ? {serial_audio_in_i, hist_r[23:1]} : {hist_r[22:0], serial_audio_in_i};
    assign cur_idx   = wc_edge ? 6'h00 : idx_r;
    assign cap_pos   = 6'(wlen) - 6'h01 + (i2s_mode ? 6'h01 : 6'h00);
    assign cap_lr    = rj_mode ? wc_edge : (cur_idx == cap_pos);
    assign cap_src   = rj_mode ? hist_r : hist_nxt;
    assign cap_word  = lsb_mode ? (cap_src & ~(24'hFF_FFFF >> wlen)) : (cap_src << (5'h18 - wlen));
    assign cap_right = rj_mode ? ~wc_prev_r : (i2s_mode ? frame_word_clock_i : ~frame_word_clock_i);

    // Format settings are quasi-static; two flops bring them into the link domain.
    always_ff @(posedge audio_bit_clock_i or negedge ext_rst_n_i)
    begin
        if (!ext_rst_n_i)
        begin
            fmt_s1_r <= 5'h00;
            fmt_s2_r <= 5'h00;
        end
        else
        begin
            fmt_s1_r <= {cfg_r.width_sel, cfg_r.lsb_first, cfg_r.frame};
            fmt_s2_r <= fmt_s1_r;
        end
    end

    // Data and word clock are taken on the rising bit clock edge.
    always_ff @(posedge audio_bit_clock_i or negedge ext_rst_n_i)
    begin
        if (!ext_rst_n_i)
        begin
            wc_prev_r <= 1'b0;
            hist_r    <= 24'h00_0000;
            idx_r     <= 6'h00;
        end
        else
        begin
            wc_prev_r <= frame_word_clock_i;
            hist_r    <= hist_nxt;
            idx_r     <= (cur_idx == 6'h3F) ? cur_idx : cur_idx + 6'h01;
        end
    end

    // A completed right word publishes the pair and toggles the frame flag.
    always_ff @(posedge audio_bit_clock_i or negedge ext_rst_n_i)
    begin
        if (!ext_rst_n_i)
        begin
            left_tmp_r  <= 24'h00_0000;
            link_pair_r <= '0;
            frame_tgl_r <= 1'b0;
        end
        else if (cap_lr && !cap_right)
            left_tmp_r <= cap_word;
        else if (cap_lr)
        begin
            link_pair_r <= {left_tmp_r, cap_word};
            frame_tgl_r <= ~frame_tgl_r;
        end
    end

    // Logic clocked by the core clock.
    afe_cfg_t    cfg_nxt;
    logic [6:0]  caddr_r;
    logic signed [27:0] coef_mem [COEF_WORDS];
    logic signed [27:0] st_mem [ST_WORDS];
    logic [31:0] rdata_r;
    logic [2:0]  tgl_sync_r;
    logic [2:0]  mclk_sync_r;
    afe_pair_t   in_pair_r;
    logic [15:0] per_cnt_r;
    logic [15:0] period_r;
    logic [10:0] mclk_cnt_r;
    logic [10:0] mclk_frame_r;
    logic [27:0] phase_r;

    // Bus decode.
    wire        acc_ph   = psel_i & penable_i;
    wire        wr_en    = acc_ph & pwrite_i;
    wire        setup_ph = psel_i & ~penable_i;
    wire        caddr_ok = caddr_r < 7'(COEF_WORDS);
    wire        coef_wr  = wr_en && (paddr_i == REG_CDATA);
    logic [31:0] rd_mux;
    logic        hit;

    // Zero-wait slave: every access completes in its first access cycle.
    assign pready_o  = acc_ph;
    assign pslverr_o = acc_ph & ~hit;
    assign prdata_o  = rdata_r;

    // Input rate and master clock ratio measured per frame.
    wire rate_ok = (period_r >= 16'(PERIOD_MIN)) && (period_r <= 16'(PERIOD_MAX))
                   && (per_cnt_r <= 16'(PERIOD_MAX));
    wire mclk_ok = (mclk_frame_r + 11'h001 >= 11'(cfg_r.mclk_ratio))
                   && (mclk_frame_r <= 11'(cfg_r.mclk_ratio) + 11'h001);

    // Read multiplexer and address hit.
    always_comb
    begin
        hit    = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr_i)
            REG_CTRL:   rd_mux = {29'h0, cfg_r.channel_eq_bypass, cfg_r.eq_global_bypass};
            REG_FMT:    rd_mux = {26'h0, cfg_r.width_sel, 1'b0, cfg_r.lsb_first, cfg_r.frame};
            REG_FILT:   rd_mux = {22'h0, cfg_r.filt_en};
            REG_GAIN:   rd_mux = {23'h0, cfg_r.gain_code};
            REG_RATIO:  rd_mux = {22'h0, cfg_r.mclk_ratio};
            REG_CADDR:  rd_mux = {25'h0, caddr_r};
            REG_CDATA:  rd_mux = caddr_ok ? {4'h0, coef_mem[caddr_r]} : 32'h0000_0000;
            REG_STAT:   rd_mux = {30'h0, mclk_ok, rate_ok};
            REG_PERIOD: rd_mux = {16'h0, period_r};
            default:    hit = 1'b0;
        endcase
    end

    // Register write decode.
    always_comb
    begin
        cfg_nxt = cfg_r;
        if (wr_en)
        begin
            case (paddr_i)
                REG_CTRL:
                begin
                    cfg_nxt.eq_global_bypass  = pwdata_i[CTRL_GBYP_BIT];
                    cfg_nxt.channel_eq_bypass = pwdata_i[CTRL_CHB_LSB +: 2];
                end
                REG_FMT:
                begin
                    cfg_nxt.frame     = afe_frame_t'(pwdata_i[FMT_FRM_LSB +: 2]);
                    cfg_nxt.lsb_first = pwdata_i[FMT_LSBF_BIT];
                    cfg_nxt.width_sel = pwdata_i[FMT_WID_LSB +: 2];
                end
                REG_FILT:  cfg_nxt.filt_en    = pwdata_i[9:0];
                REG_GAIN:  cfg_nxt.gain_code  = pwdata_i[8:0];
                REG_RATIO: cfg_nxt.mclk_ratio = pwdata_i[9:0];
                default:   cfg_nxt = cfg_r;
            endcase
        end
    end

    // Configuration, coefficient address and read data.
    always_ff @(posedge core_clk_i or negedge ext_rst_n_i)
    begin
        if (!ext_rst_n_i)
        begin
            cfg_r   <= CFG_RST;
            caddr_r <= 7'h00;
            rdata_r <= 32'h0000_0000;
        end
        else if (sys_rst_i)
        begin
            cfg_r   <= CFG_RST;
            caddr_r <= 7'h00;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            if (setup_ph)
                rdata_r <= rd_mux;
            if (wr_en && paddr_i == REG_CADDR)
                caddr_r <= pwdata_i[6:0];
            else if (coef_wr)
                caddr_r <= caddr_r + 7'h01;
        end
    end

    // Coefficient store: b0, b1, b2, a1, a2 per section, a terms pre-negated.
    always_ff @(posedge core_clk_i)
    begin
        if (coef_wr && caddr_ok)
            coef_mem[caddr_r] <= pwdata_i[27:0];
    end

    // Synchronisers for the frame toggle and the master clock pin.
    always_ff @(posedge core_clk_i or negedge ext_rst_n_i)
    begin
        if (!ext_rst_n_i)
        begin
            tgl_sync_r  <= 3'h0;
            mclk_sync_r <= 3'h0;
        end
        else
        begin
            tgl_sync_r  <= {tgl_sync_r[1:0], frame_tgl_r};
            mclk_sync_r <= {mclk_sync_r[1:0], master_clock_in_i};
        end
    end

    wire frame_evt = tgl_sync_r[2] ^ tgl_sync_r[1];
    wire mclk_rise = mclk_sync_r[1] & ~mclk_sync_r[2];

    // Frame period, master clock count and the captured input pair.
    always_ff @(posedge core_clk_i or negedge ext_rst_n_i)
    begin
        if (!ext_rst_n_i)
        begin
            per_cnt_r <= 16'h0000;
            period_r  <= 16'h0000;
            mclk_cnt_r <= 11'h000;
            mclk_frame_r <= 11'h000;
            in_pair_r <= '0;
        end
        else if (sys_rst_i)
        begin
            per_cnt_r <= 16'h0000;
            period_r  <= 16'h0000;
            mclk_cnt_r <= 11'h000;
            mclk_frame_r <= 11'h000;
            in_pair_r <= '0;
        end
        else if (frame_evt)
        begin
            per_cnt_r    <= 16'h0001;
            period_r     <= per_cnt_r;
            mclk_cnt_r   <= {10'h000, mclk_rise};
            mclk_frame_r <= mclk_cnt_r;
            in_pair_r    <= link_pair_r;
        end
        else
        begin
            per_cnt_r  <= (per_cnt_r == 16'hFFFF) ? per_cnt_r : per_cnt_r + 16'h0001;
            mclk_cnt_r <= (mclk_cnt_r == 11'h7FF) ? mclk_cnt_r : mclk_cnt_r + 11'(mclk_rise);
        end
    end

    // Fractional phase accumulator ticking at the processing rate.
    wire [31:0] phase_sum = 32'(phase_r) + FS_PROC_HZ;
    wire        tick      = phase_sum >= CLK_HZ;

    always_ff @(posedge core_clk_i or negedge ext_rst_n_i)
    begin
        if (!ext_rst_n_i)
            phase_r <= 28'h000_0000;
        else if (sys_rst_i)
            phase_r <= 28'h000_0000;
        else
            phase_r <= tick ? 28'(phase_sum - CLK_HZ) : phase_sum[27:0];
    end

    // Filter engine and output stage.
    afe_state_t  state_r;
    logic        ch_r;
    logic [3:0]  sec_r;
    logic [2:0]  term_r;
    logic signed [59:0] acc_r;
    logic signed [27:0] x_r;
    afe_pair_t   out_r;
    logic        valid_r;
    logic signed [27:0] operand;

    function automatic logic signed [27:0] sat28(input logic signed [59:0] v);
        if (v > DATA_MAX)
            return DATA_MAX[27:0];
        else if (v < DATA_MIN)
            return DATA_MIN[27:0];
        else
            return v[27:0];
    endfunction

    wire [6:0] st_base  = 7'((int'(ch_r) * NUM_SEC + int'(sec_r)) * 4);
    wire [6:0] coef_idx = 7'(int'(ch_r) * NUM_SEC * NUM_TERM + int'(sec_r) * NUM_TERM + int'(term_r));
    wire       byp_left  = cfg_r.eq_global_bypass | cfg_r.channel_eq_bypass[0];
    wire       byp_right = cfg_r.eq_global_bypass | cfg_r.channel_eq_bypass[1];
    wire       sec_on    = cfg_r.filt_en[sec_r];
    wire       last_sec  = sec_r == 4'(NUM_SEC - 1);
    wire       last_term = term_r == 3'(NUM_TERM - 1);

    // Operand for the current tap: input, x1, x2, y1, y2.
    always_comb
    begin
        case (term_r)
            3'h0:    operand = x_r;
            3'h1:    operand = st_mem[st_base];
            3'h2:    operand = st_mem[st_base + 7'h01];
            3'h3:    operand = st_mem[st_base + 7'h02];
            default: operand = st_mem[st_base + 7'h03];
        endcase
    end

    wire signed [55:0] prod    = coef_mem[coef_idx] * operand;
    wire signed [59:0] acc_nxt = acc_r + 60'(prod);
    wire signed [27:0] y_sec   = sat28(acc_nxt >>> COEF_FRAC);

    // Gain: table mantissa for the 0.5 dB step, shift for each 12 steps.
    wire [8:0]  gcode  = (cfg_r.gain_code > GAIN_MAX_CODE) ? GAIN_MAX_CODE : cfg_r.gain_code;
    wire [4:0]  gshift = 5'(gcode / 9'(GAIN_STEPS));
    wire [3:0]  gsel   = 4'(gcode % 9'(GAIN_STEPS));
    wire signed [44:0] gprod = x_r * $signed({1'b0, GAIN_MANT[gsel]});
    wire signed [59:0] gwide = (60'(gprod) <<< GAIN_TOP_SHIFT) >>> (GAIN_MANT_FRAC + int'(gshift));
    wire signed [27:0] gsat  = sat28(gwide);

    assign eq_out_valid_o = valid_r;
    assign eq_out_o       = out_r;

    // Filter state memory: x1, x2, y1, y2 per channel and section.
    always_ff @(posedge core_clk_i or negedge ext_rst_n_i)
    begin
        if (!ext_rst_n_i)
            for (int i = 0; i < ST_WORDS; i++)
                st_mem[i] <= 28'h000_0000;
        else if (sys_rst_i)
            for (int i = 0; i < ST_WORDS; i++)
                st_mem[i] <= 28'h000_0000;
        else if (state_r == S_MAC && sec_on && last_term)
        begin
            st_mem[st_base]          <= x_r;
            st_mem[st_base + 7'h01]  <= st_mem[st_base];
            st_mem[st_base + 7'h02]  <= y_sec;
            st_mem[st_base + 7'h03]  <= st_mem[st_base + 7'h02];
        end
    end

    // Sequencer: left then right, each through every enabled section unless bypassed, then gain.
    always_ff @(posedge core_clk_i or negedge ext_rst_n_i)
    begin
        if (!ext_rst_n_i)
        begin
            state_r <= S_IDLE;
            {ch_r, sec_r, term_r, acc_r, x_r, out_r, valid_r} <= '0;
        end
        else if (sys_rst_i)
        begin
            state_r <= S_IDLE;
            {ch_r, sec_r, term_r, acc_r, x_r, out_r, valid_r} <= '0;
        end
        else
        begin
            valid_r <= 1'b0;
            case (state_r)
                S_IDLE:
                    if (tick)
                    begin
                        ch_r    <= 1'b0;
                        {sec_r, term_r, acc_r} <= '0;
                        x_r     <= {in_pair_r.left, 4'h0};
                        state_r <= byp_left ? S_GAIN : S_MAC;
                    end
                S_MAC:
                    if (sec_on && !last_term)
                    begin
                        acc_r  <= acc_nxt;
                        term_r <= term_r + 3'h1;
                    end
                    else
                    begin
                        if (sec_on)
                            x_r <= y_sec;
                        {term_r, acc_r} <= '0;
                        sec_r   <= last_sec ? 4'h0 : sec_r + 4'h1;
                        state_r <= last_sec ? S_GAIN : S_MAC;
                    end
                S_GAIN:
                    if (!ch_r)
                    begin
                        out_r.left <= gsat[27:4];
                        ch_r       <= 1'b1;
                        x_r        <= {in_pair_r.right, 4'h0};
                        state_r    <= byp_right ? S_GAIN : S_MAC;
                    end
                    else
                    begin
                        out_r.right <= gsat[27:4];
                        valid_r     <= 1'b1;
                        state_r     <= S_IDLE;
                    end
                default: state_r <= S_IDLE;
            endcase
        end
    end

endmodule

// ==== rtl/afe_pkg.sv ====
// How it works
// - Accept input sample rates 32 to 192 kHz.
// - Deliver two channels at 96 kHz rate.
// - Ten 28-bit biquads per channel.
// - Prescale, DC, high-pass, de-emphasis, bass, treble.
// - Global bypass skips EQ on both channels.
// - Per-channel bypass skips EQ for that channel.
// - Reset low clears outputs and sets registers to their defaults.
// - Reset pin acts without the clock.
// - Master clock ratio defaults to 256 fs.
// - Six framings: I2S, left, right; LSB/MSB first.
// - Word widths 16, 18, 20, 24 bits.
// - Gain +48 to -80 dB, 0.5 dB steps.
// - Control port keeps up with 400 kB/s.
// - Master clock ratio 576 fs is supported.
// - Coefficient writes auto-increment the address.
package afe_pkg;

    // Core clock and audio rates.
    localparam int unsigned CLK_HZ     = 200_000_000;
    localparam int unsigned FS_MIN_HZ  = 32_000;
    localparam int unsigned FS_MAX_HZ  = 192_000;
    localparam int unsigned FS_PROC_HZ = 96_000;
    localparam int unsigned PERIOD_MIN = CLK_HZ / FS_MAX_HZ;
    localparam int unsigned PERIOD_MAX = CLK_HZ / FS_MIN_HZ;

    // Register byte offsets.
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_FMT    = 8'h04;
    localparam logic [7:0] REG_FILT   = 8'h08;
    localparam logic [7:0] REG_GAIN   = 8'h0C;
    localparam logic [7:0] REG_RATIO  = 8'h10;
    localparam logic [7:0] REG_CADDR  = 8'h14;
    localparam logic [7:0] REG_CDATA  = 8'h18;
    localparam logic [7:0] REG_STAT   = 8'h1C;
    localparam logic [7:0] REG_PERIOD = 8'h20;

    // Field positions.
    localparam int unsigned CTRL_GBYP_BIT = 0;
    localparam int unsigned CTRL_CHB_LSB  = 1;
    localparam int unsigned FMT_FRM_LSB   = 0;
    localparam int unsigned FMT_LSBF_BIT  = 2;
    localparam int unsigned FMT_WID_LSB   = 4;

    // Datapath geometry.
    localparam int unsigned NUM_SEC    = 10;
    localparam int unsigned NUM_TERM   = 5;
    localparam int unsigned COEF_WORDS = 100;
    localparam int unsigned ST_WORDS   = 80;
    localparam int unsigned COEF_FRAC  = 23;
    localparam logic signed [59:0] DATA_MAX = 60'sh000_0000_07FF_FFFF;
    localparam logic signed [59:0] DATA_MIN = -60'sh000_0000_0800_0000;

    // Gain law: code 0 is +48 dB, each code is -0.5 dB.
    localparam logic [8:0]  GAIN_RST       = 9'h060;
    localparam logic [8:0]  GAIN_MAX_CODE  = 9'h100;
    localparam int unsigned GAIN_STEPS     = 12;
    localparam int unsigned GAIN_TOP_SHIFT = 8;
    localparam int unsigned GAIN_MANT_FRAC = 15;
    localparam logic [15:0] GAIN_MANT [GAIN_STEPS] = '{16'h8000, 16'h78D7, 16'h7215, 16'h6BB3, 16'h65AD,
        16'h5FFD, 16'h5A9E, 16'h558C, 16'h50C3, 16'h4C3F, 16'h47FB, 16'h43F4};

    // Master clock ratios.
    localparam logic [9:0] RATIO_RST   = 10'h100;
    localparam logic [9:0] RATIO_VIDEO = 10'h240;

    typedef enum logic [1:0] {FRM_I2S, FRM_LEFT, FRM_RIGHT, FRM_SPARE} afe_frame_t;

    typedef struct packed {
        logic signed [23:0] left;
        logic signed [23:0] right;
    } afe_pair_t;

    typedef struct packed {
        logic       eq_global_bypass;
        logic [1:0] channel_eq_bypass;
        afe_frame_t frame;
        logic       lsb_first;
        logic [1:0] width_sel;
        logic [9:0] filt_en;
        logic [8:0] gain_code;
        logic [9:0] mclk_ratio;
    } afe_cfg_t;

    localparam afe_cfg_t CFG_RST = '{1'b0, 2'h0, FRM_I2S, 1'b0, 2'h3, 10'h000, GAIN_RST, RATIO_RST};

endpackage
